// ===== logic/sfs_queue.v
// sample queue, status flags and interrupt of the optical front end
`timescale 1ns/1ps
`include "sfs_regs.vh"
module sfs_queue (
    sys_clk,
    rst,
    brownout_detect,
    led_headroom_low,
    push_valid,
    push_data,
    frame_done,
    overrun_detect,
    window_one_out,
    reg_addr,
    reg_wr_en,
    reg_rd_en,
    reg_wdata,
    reg_rdata,
    reg_rd_valid,
    interrupt_out_n
);
    input wire sys_clk;
    input wire rst;
    input wire brownout_detect;
    input wire [3:0] led_headroom_low;
    input wire push_valid;
    input wire [23:0] push_data;
    input wire frame_done;
    input wire overrun_detect;
    input wire window_one_out;
    input wire [7:0] reg_addr;
    input wire reg_wr_en;
    input wire reg_rd_en;
    input wire [7:0] reg_wdata;
    output reg [7:0] reg_rdata;
    output reg reg_rd_valid;
    output reg interrupt_out_n;

    // sample storage, one 24-bit word per location
    reg [23:0] queue_mem [0:255];
    // pointers, counts and byte position within the current sample
    reg [7:0] write_pointer_q;
    reg [7:0] read_pointer_q;
    reg [8:0] count_q;
    reg [6:0] lost_sample_counter_q;
    reg [1:0] byte_idx_q;
    // software-written configuration
    reg [7:0] watermark_q;
    reg [7:0] queue_cfg_q;
    reg shutdown_bit_q;
    reg [7:0] int_en_one_q;
    reg [7:0] int_en_two_q;
    // sticky status flags
    reg power_loss_flag_q;
    reg wm_flag_q;
    reg wm_armed_q;
    reg frame_rdy_q;
    reg data_rdy_q;
    reg window_one_flag_q;
    reg overrun_flag_q;
    reg [3:0] led_headroom_low_flag_q;
    // previous synchronised brownout level for edge finding
    reg brownout_prev_q;

    // pin inputs, synchronised before any logic sees them
    wire [4:0] pins_sync;
    wire brownout_s;
    wire [3:0] led_low_s;

    sfs_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({brownout_detect, led_headroom_low}),
        .sync_out(pins_sync)
    );

    assign brownout_s = pins_sync[4];
    assign led_low_s = pins_sync[3:0];

    // decoded accesses
    wire brownout_rise = brownout_s & ~brownout_prev_q;
    wire wr_queue_cfg = reg_wr_en & (reg_addr == `SFS_ADDR_QUEUE_CFG);
    wire wr_sys_cfg = reg_wr_en & (reg_addr == `SFS_ADDR_SYS_CFG);
    wire wr_rd_ptr = reg_wr_en & (reg_addr == `SFS_ADDR_RD_PTR);
    wire rd_status_one = reg_rd_en & (reg_addr == `SFS_ADDR_STATUS_ONE);
    wire rd_status_two = reg_rd_en & (reg_addr == `SFS_ADDR_STATUS_TWO);
    wire rd_data = reg_rd_en & (reg_addr == `SFS_ADDR_DATA);
    // soft reset restores registers but never touches the power-loss flag
    wire soft_reset = wr_sys_cfg & reg_wdata[`SFS_SC_SOFT_RESET];
    // brownout acts like power-on for every register except reg_rdata, reg_rd_valid, interrupt_out_n, the sync stages and brownout_prev_q
    wire init_all = brownout_rise | soft_reset;
    wire purge = wr_queue_cfg & reg_wdata[`SFS_QC_PURGE];

    // queue state
    wire queue_empty = (count_q == 9'h000);
    wire queue_full = (count_q == `SFS_QUEUE_DEPTH);
    wire rollover = queue_cfg_q[`SFS_QC_ROLLOVER];
    // a data read of the last byte of a present sample retires it
    wire sample_done = rd_data & ~queue_empty & (byte_idx_q == `SFS_LAST_BYTE);
    // a retire in the same cycle frees a slot, so the push is not a loss
    wire full_eff = queue_full & ~sample_done;
    wire push_store = push_valid & (~full_eff | rollover);
    wire push_lost = push_valid & full_eff;
    wire stat_clr_on_data = rd_data & queue_cfg_q[`SFS_QC_STAT_CLR];
    wire clr_queue_flags = rd_status_one | stat_clr_on_data;

    // byte of the current sample, most significant byte first
    reg [23:0] cur_sample;
    reg [7:0] cur_byte;
    always @* begin
        cur_sample = queue_mem[read_pointer_q];
        case (byte_idx_q)
            2'h0: cur_byte = cur_sample[23:16];
            2'h1: cur_byte = cur_sample[15:8];
            default: cur_byte = cur_sample[7:0];
        endcase
    end

    // fill level after this cycle, used for the watermark compare
    reg [8:0] count_d;
    always @* begin
        count_d = count_q;
        if (push_store & ~full_eff & ~sample_done) begin
            count_d = count_q + 9'h001;
        end else if (sample_done & ~push_store) begin
            count_d = count_q - 9'h001;
        end
    end
    // watermark level: depth minus the programmed free-space setting
    wire [8:0] wm_level = `SFS_QUEUE_DEPTH - {1'b0, watermark_q};
    wire wm_cond = push_store & (count_d >= wm_level);
    // type one fires once until a read re-arms it; type zero every sample
    wire wm_set = wm_cond & (~queue_cfg_q[`SFS_QC_WM_TYPE] | wm_armed_q);

    // storage write, no reset needed on the array
    always @(posedge sys_clk) begin
        if (push_store) begin
            queue_mem[write_pointer_q] <= push_data;
        end
    end

    // pointers, count and lost-sample counter
    always @(posedge sys_clk) begin
        if (rst | init_all | purge) begin
            write_pointer_q <= 8'h00;
            read_pointer_q <= 8'h00;
            count_q <= 9'h000;
            lost_sample_counter_q <= 7'h00;
            byte_idx_q <= 2'h0;
        end else if (wr_rd_ptr) begin
            // replay: host moves the read pointer, count follows the gap
            read_pointer_q <= reg_wdata;
            count_q <= {1'b0, write_pointer_q - reg_wdata};
            byte_idx_q <= 2'h0;
        end else begin
            if (push_store) begin
                write_pointer_q <= write_pointer_q + 8'h01;
            end
            // rollover on full pushes the read pointer past the lost sample
            if (sample_done | (push_store & full_eff)) begin
                read_pointer_q <= read_pointer_q + 8'h01;
            end
            count_q <= count_d;
            if (rd_data & ~queue_empty) begin
                byte_idx_q <= (byte_idx_q == `SFS_LAST_BYTE) ? 2'h0 : byte_idx_q + 2'h1;
            end
            // a finished read wins over a loss in the same cycle
            if (sample_done) begin
                lost_sample_counter_q <= 7'h00;
            end else if (push_lost & (lost_sample_counter_q != `SFS_LOST_MAX)) begin
                lost_sample_counter_q <= lost_sample_counter_q + 7'h01;
            end
        end
    end

    // configuration registers
    always @(posedge sys_clk) begin
        if (rst | init_all) begin
            watermark_q <= `SFS_RST_WATERMARK;
            queue_cfg_q <= `SFS_RST_QUEUE_CFG;
            shutdown_bit_q <= 1'b0;
            int_en_one_q <= 8'h00;
            int_en_two_q <= 8'h00;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `SFS_ADDR_WATERMARK: begin
                    watermark_q <= reg_wdata;
                end
                `SFS_ADDR_QUEUE_CFG: begin
                    // purge is self-clearing and never stored
                    queue_cfg_q <= {4'h0, reg_wdata[`SFS_QC_STAT_CLR:`SFS_QC_ROLLOVER], 1'b0};
                end
                `SFS_ADDR_SYS_CFG: begin
                    shutdown_bit_q <= reg_wdata[`SFS_SC_SHUTDOWN];
                end
                `SFS_ADDR_INT_EN_ONE: begin
                    int_en_one_q <= reg_wdata;
                end
                `SFS_ADDR_INT_EN_TWO: begin
                    int_en_two_q <= reg_wdata;
                end
                default: begin
                    watermark_q <= watermark_q;
                end
            endcase
        end
    end

    // power-loss flag: set by power-on and brownout only, set wins over clear
    always @(posedge sys_clk) begin
        if (rst) begin
            power_loss_flag_q <= 1'b1;
        end else if (brownout_rise) begin
            power_loss_flag_q <= 1'b1;
        end else if (rd_status_one | (wr_sys_cfg & reg_wdata[`SFS_SC_SHUTDOWN])) begin
            power_loss_flag_q <= 1'b0;
        end
    end

    // queue and window flags of status one; a set in the clear cycle survives
    always @(posedge sys_clk) begin
        if (rst | init_all) begin
            wm_flag_q <= 1'b0;
            wm_armed_q <= 1'b1;
            frame_rdy_q <= 1'b0;
            data_rdy_q <= 1'b0;
            window_one_flag_q <= 1'b0;
            brownout_prev_q <= brownout_s & ~rst;
        end else begin
            wm_flag_q <= wm_set | (wm_flag_q & ~clr_queue_flags);
            // re-arm once the host has drained a sample
            if (wm_set) begin
                wm_armed_q <= 1'b0;
            end else if (sample_done) begin
                wm_armed_q <= 1'b1;
            end
            frame_rdy_q <= frame_done | (frame_rdy_q & ~clr_queue_flags);
            data_rdy_q <= push_store | (data_rdy_q & ~clr_queue_flags);
            window_one_flag_q <= window_one_out | (window_one_flag_q & ~rd_status_one);
            brownout_prev_q <= brownout_s;
        end
    end

    // status two flags, cleared together by a status-two read
    always @(posedge sys_clk) begin
        if (rst | init_all) begin
            overrun_flag_q <= 1'b0;
            led_headroom_low_flag_q <= 4'h0;
        end else begin
            overrun_flag_q <= overrun_detect | (overrun_flag_q & ~rd_status_two);
            led_headroom_low_flag_q <= led_low_s | (led_headroom_low_flag_q & {4{~rd_status_two}});
        end
    end

    // assembled status words
    wire [7:0] status_one = {wm_flag_q, frame_rdy_q, data_rdy_q, 3'h0, window_one_flag_q, power_loss_flag_q};
    wire [7:0] status_two = {overrun_flag_q, 3'h0, led_headroom_low_flag_q};

    // read mux; unlisted offsets answer zero
    reg [7:0] rdata_d;
    always @* begin
        case (reg_addr)
            `SFS_ADDR_STATUS_ONE: rdata_d = status_one;
            `SFS_ADDR_STATUS_TWO: rdata_d = status_two;
            `SFS_ADDR_WR_PTR: rdata_d = write_pointer_q;
            `SFS_ADDR_RD_PTR: rdata_d = read_pointer_q;
            `SFS_ADDR_CNT_HIGH: rdata_d = {count_q[8], lost_sample_counter_q};
            `SFS_ADDR_CNT_LOW: rdata_d = count_q[7:0];
            // empty queue returns the idle pattern and moves nothing
            `SFS_ADDR_DATA: rdata_d = queue_empty ? `SFS_RST_DATA : cur_byte;
            `SFS_ADDR_WATERMARK: rdata_d = watermark_q;
            `SFS_ADDR_QUEUE_CFG: rdata_d = queue_cfg_q;
            `SFS_ADDR_SYS_CFG: rdata_d = {6'h00, shutdown_bit_q, 1'b0};
            `SFS_ADDR_INT_EN_ONE: rdata_d = int_en_one_q;
            `SFS_ADDR_INT_EN_TWO: rdata_d = int_en_two_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // read data is captured with the pre-clear value of the flags
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `SFS_RST_BYTE;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rdata_d;
            end
        end
    end

    // interrupt: enabled flags, plus the power-loss flag with no mask at all
    wire int_any = (|(status_one & int_en_one_q)) | (|(status_two & int_en_two_q)) | power_loss_flag_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~int_any;
        end
    end
endmodule

// ===== logic/sfs_regs.vh
// register offsets, field positions and reset values of the sample queue block
`ifndef SFS_REGS_VH
`define SFS_REGS_VH

// register offsets on the internal register port
`define SFS_ADDR_STATUS_ONE 8'h00
`define SFS_ADDR_STATUS_TWO 8'h01
`define SFS_ADDR_WR_PTR 8'h03
`define SFS_ADDR_RD_PTR 8'h04
`define SFS_ADDR_CNT_HIGH 8'h05
`define SFS_ADDR_CNT_LOW 8'h06
`define SFS_ADDR_DATA 8'h07
`define SFS_ADDR_WATERMARK 8'h08
`define SFS_ADDR_QUEUE_CFG 8'h09
`define SFS_ADDR_SYS_CFG 8'h11
`define SFS_ADDR_INT_EN_ONE 8'h58
`define SFS_ADDR_INT_EN_TWO 8'h59

// status one bit positions
`define SFS_S1_WATERMARK 7
`define SFS_S1_FRAME_RDY 6
`define SFS_S1_DATA_RDY 5
`define SFS_S1_WINDOW_ONE 1
`define SFS_S1_POWER_LOSS 0

// status two bit positions
`define SFS_S2_OVERRUN 7

// queue configuration bit positions
`define SFS_QC_PURGE 4
`define SFS_QC_STAT_CLR 3
`define SFS_QC_WM_TYPE 2
`define SFS_QC_ROLLOVER 1

// system configuration bit positions
`define SFS_SC_SHUTDOWN 1
`define SFS_SC_SOFT_RESET 0

// reset values
`define SFS_RST_WATERMARK 8'h7f
`define SFS_RST_QUEUE_CFG 8'h08
`define SFS_RST_DATA 8'hff
`define SFS_RST_BYTE 8'h00

// queue geometry and counter limits
`define SFS_QUEUE_DEPTH 9'h100
`define SFS_LOST_MAX 7'h7f
`define SFS_LAST_BYTE 2'h2

`endif

// ===== logic/sfs_sync.v
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module sfs_sync #(
    parameter WIDTH = 1
) (
    sys_clk,
    rst,
    async_in,
    sync_out
);
    input wire sys_clk;
    input wire rst;
    input wire [WIDTH-1:0] async_in;
    output wire [WIDTH-1:0] sync_out;

    // first stage may go metastable; only the second stage reads it
    reg [WIDTH-1:0] meta_q;
    // second stage is the clean copy seen by the block
    reg [WIDTH-1:0] sync_q;

    // both stages clear on reset so the block starts from a known level
    always @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ===== tb/sfs_host.sv
// host processor model on the register port
`timescale 1ns/1ps
module sfs_host (
    input wire sys_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid
);
    // idle port from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = 8'h00;
    end
    // one write; data scrambled after release so stale data never helps
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // one byte read, answer taken one cycle after the taking edge
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(posedge sys_clk);
        // a missing answer poisons the byte so the compare cannot pass
        d = reg_rd_valid ? reg_rdata : 8'hxx;
    endtask
    // whole sample by a burst on the fixed data address, msb first
    task rd_sample(output logic [23:0] s);
        logic [7:0] b;
        rd(8'h07, b);
        s[23:16] = b;
        rd(8'h07, b);
        s[15:8] = b;
        rd(8'h07, b);
        s[7:0] = b;
    endtask
endmodule

// ===== tb/sfs_queue_props.sv
// checker on the ports of the sample queue block
`timescale 1ns/1ps
module sfs_queue_props (
    input wire sys_clk,
    input wire rst,
    input wire brownout_detect,
    input wire overrun_detect,
    input wire window_one_out,
    input wire [7:0] reg_addr,
    input wire reg_rd_en,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid,
    input wire interrupt_out_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // reads of the two status registers
    sequence s_rd_one;
        reg_rd_en && reg_addr == 8'h00;
    endsequence
    sequence s_rd_two;
        reg_rd_en && reg_addr == 8'h01;
    endsequence
    property p_rd_answer;
        reg_rd_en |=> reg_rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_quiet;
        !reg_rd_en |=> !reg_rd_valid;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read");
    property p_unmapped;
        reg_rd_en && reg_addr == 8'h02 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // power-loss flag comes up set and is never masked
    property p_pwr_on;
        $fell(rst) |-> ##1 !interrupt_out_n;
    endproperty
    a_pwr_on: assert property (p_pwr_on) else $error("no interrupt after reset");
    // sync stages plus edge detect delay the brownout
    property p_brownout;
        $rose(brownout_detect) |-> ##[2:8] !interrupt_out_n;
    endproperty
    a_brownout: assert property (p_brownout) else $error("no interrupt on brownout");
    property p_window;
        window_one_out ##1 s_rd_one |=> reg_rdata[1];
    endproperty
    a_window: assert property (p_window) else $error("window flag missing");
    property p_overrun;
        overrun_detect ##1 s_rd_two |=> reg_rdata[7];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun flag missing");
    // first read clears, so a read three cycles later sees zero
    property p_rd_clear;
        (reg_rd_en && reg_addr == 8'h01 && !overrun_detect) ##1 !overrun_detect [*2] ##1 s_rd_two
            |=> !reg_rdata[7];
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("overrun flag not cleared");
endmodule
bind sfs_queue sfs_queue_props chk (.sys_clk(sys_clk), .rst(rst), .brownout_detect(brownout_detect),
    .overrun_detect(overrun_detect), .window_one_out(window_one_out), .reg_addr(reg_addr),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .interrupt_out_n(interrupt_out_n));

// ===== tb/sfs_queue_tb.sv
// self-checking bench for the sample queue block
`timescale 1ns/1ps
module sfs_queue_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic brownout_detect = 1'b0;
    logic [3:0] led_headroom_low = 4'h0;
    logic push_valid = 1'b0;
    logic [23:0] push_data = 24'h000000;
    logic frame_done = 1'b0;
    logic overrun_detect = 1'b0;
    logic window_one_out = 1'b0;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_wr_en, reg_rd_en, reg_rd_valid, interrupt_out_n;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int i;
    logic [7:0] b;
    logic [23:0] s;
    // offsets and power-on values
    logic [7:0] ra [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h11, 8'h58, 8'h59};
    logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h7f, 8'h08, 8'h00, 8'h00, 8'h00};
    always #2 sys_clk = ~sys_clk;
    sfs_queue uut (.sys_clk(sys_clk), .rst(rst), .brownout_detect(brownout_detect),
        .led_headroom_low(led_headroom_low), .push_valid(push_valid), .push_data(push_data),
        .frame_done(frame_done), .overrun_detect(overrun_detect), .window_one_out(window_one_out),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .interrupt_out_n(interrupt_out_n));
    sfs_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rx(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, b);
        chk({16'h0000, b}, {16'h0000, e});
    endtask
    task sx(input logic [23:0] e);
        host.rd_sample(s);
        chk(s, e);
    endtask
    task push(input logic [23:0] d);
        @(posedge sys_clk);
        push_data <= d;
        push_valid <= 1'b1;
        @(posedge sys_clk);
        push_valid <= 1'b0;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // distinct sample per index, bytes differ so order errors show
    function logic [23:0] smp(input int k);
        return {k[7:0], ~k[7:0], 8'h5a};
    endfunction
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard, far above the thousand or so cycles needed
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict;
        end
    end
    initial begin
        tick(5);
        rst <= 1'b0;
        rx(8'h00, 8'h01);
        tick(2);
        chk({23'h0, interrupt_out_n}, 24'h1);
        host.wr(8'h03, 8'h55);
        host.wr(8'h02, 8'h55);
        for (i = 0; i < 12; i++) rx(ra[i], rv[i]);
        for (i = 0; i < 3; i++) push(smp(i));
        rx(8'h03, 8'h03);
        rx(8'h06, 8'h03);
        for (i = 0; i < 3; i++) begin
            sx(smp(i));
            rx(8'h04, 8'(i + 1));
        end
        // fill past full with drop-new, write pointer wraps
        for (i = 0; i < 258; i++) push(smp(i + 8));
        rx(8'h03, 8'h03);
        rx(8'h05, 8'h82);
        rx(8'h06, 8'h00);
        rx(8'h00, 8'ha0);
        sx(smp(8));
        rx(8'h05, 8'h00);
        rx(8'h06, 8'hff);
        for (i = 0; i < 131; i++) push(smp(i));
        rx(8'h05, 8'hff);
        host.wr(8'h09, 8'h0a);
        push(smp(99));
        rx(8'h03, 8'h05);
        rx(8'h04, 8'h05);
        sx(smp(10));
        host.wr(8'h09, 8'h18);
        rx(8'h09, 8'h08);
        for (i = 3; i < 7; i++) rx(8'(i), 8'h00);
        push(smp(1));
        push(smp(2));
        frame_done <= 1'b1;
        tick(1);
        frame_done <= 1'b0;
        sx(smp(1));
        rx(8'h00, 8'h00);
        host.wr(8'h04, 8'h00);
        rx(8'h06, 8'h02);
        sx(smp(1));
        // watermark at one sample, fire-once type, data reads leave flags alone
        host.wr(8'h08, 8'hff);
        host.wr(8'h09, 8'h04);
        rx(8'h09, 8'h04);
        push(smp(3));
        rx(8'h00, 8'ha0);
        push(smp(4));
        sx(smp(2));
        rx(8'h00, 8'h20);
        push(smp(5));
        rx(8'h00, 8'ha0);
        // sticky flags: set while inputs high, cleared by reads after
        window_one_out <= 1'b1;
        overrun_detect <= 1'b1;
        led_headroom_low <= 4'h5;
        tick(4);
        rx(8'h00, 8'h02);
        rx(8'h01, 8'h85);
        window_one_out <= 1'b0;
        overrun_detect <= 1'b0;
        led_headroom_low <= 4'h0;
        tick(4);
        rx(8'h01, 8'h85);
        rx(8'h01, 8'h00);
        rx(8'h00, 8'h02);
        rx(8'h00, 8'h00);
        host.wr(8'h59, 8'h01);
        led_headroom_low <= 4'h1;
        tick(6);
        chk({23'h0, interrupt_out_n}, 24'h0);
        led_headroom_low <= 4'h0;
        tick(4);
        rx(8'h01, 8'h01);
        tick(2);
        chk({23'h0, interrupt_out_n}, 24'h1);
        host.wr(8'h11, 8'h01);
        rx(8'h59, 8'h00);
        rx(8'h00, 8'h00);
        brownout_detect <= 1'b1;
        tick(8);
        brownout_detect <= 1'b0;
        chk({23'h0, interrupt_out_n}, 24'h0);
        host.wr(8'h11, 8'h02);
        tick(3);
        chk({23'h0, interrupt_out_n}, 24'h1);
        rx(8'h00, 8'h00);
        give_verdict;
    end
endmodule
